// ---- logic/eft_pkg.sv ----
// Constants for the external event filter and converter trigger block.
// Assumes a 32-bit APB slave placed inside the timer unit's register map.
package eft_pkg;

  // Register byte offsets
  localparam logic [11:0] EFT_UPPER_EVENT_CONFIG_OFS  = 12'h034;
  localparam logic [11:0] EFT_EVENT_FILTER_CTRL_OFS   = 12'h038;
  localparam logic [11:0] EFT_TRIG0_SOURCES_OFS       = 12'h03C;

  // Values after reset
  localparam logic [31:0] EFT_UPPER_EVENT_CONFIG_RST  = 32'h0000_0000;
  localparam logic [31:0] EFT_EVENT_FILTER_CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] EFT_TRIG0_SOURCES_RST       = 32'h0000_0000;

  // Writable bits; reserved positions are held at zero
  localparam logic [31:0] EFT_UPPER_EVENT_CONFIG_MASK = 32'h1F7F_F7DF;
  localparam logic [31:0] EFT_EVENT_FILTER_CTRL_MASK  = 32'hCF3C_F3CF;

  // Field layout: each upper event owns a six-bit slice
  localparam int EFT_NUM_EVENTS     = 5;
  localparam int EFT_EVENT_STRIDE   = 6;
  localparam int EFT_SRC_POS        = 0;
  localparam int EFT_POL_POS        = 2;
  localparam int EFT_EDGE_POS       = 3;
  localparam int EFT_FAST_POS       = 5;
  localparam int EFT_FCODE_POS      = 0;
  localparam int EFT_FCLK_DIV_POS   = 30;
  localparam int EFT_NUM_SOURCES    = 4;
  localparam int EFT_NUM_TRIG_SRC   = 32;

  // Edge selection codes
  localparam logic [1:0] EFT_EDGE_LEVEL   = 2'h0;
  localparam logic [1:0] EFT_EDGE_RISING  = 2'h1;
  localparam logic [1:0] EFT_EDGE_FALLING = 2'h2;
  localparam logic [1:0] EFT_EDGE_BOTH    = 2'h3;

  // Filter codes
  localparam logic [3:0] EFT_FCODE_BYPASS   = 4'h0;
  localparam logic [3:0] EFT_FCODE_FIRST_FCK = 4'h4;

  // Filter length minus one, indexed by filter code
  localparam logic [2:0] EFT_FLT_LEN_M1 [16] = '{
    3'h0, 3'h1, 3'h3, 3'h7, 3'h5, 3'h7, 3'h5, 3'h7,
    3'h5, 3'h7, 3'h4, 3'h5, 3'h7, 3'h4, 3'h5, 3'h7
  };

  // Power of two dividing the filter clock, indexed by filter code
  localparam logic [3:0] EFT_FLT_RATE_LOG2 [16] = '{
    4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h1, 4'h2, 4'h2,
    4'h3, 4'h3, 4'h4, 4'h4, 4'h4, 4'h5, 4'h5, 4'h5
  };

  // Free-running prescaler width covers divide by 8 times 32
  localparam int          EFT_PRESCALE_W   = 8;
  localparam logic [7:0]  EFT_PRESCALE_RST = 8'h00;

endpackage

// ---- logic/eft_top.sv ----
// External event 5..9 conditioning and converter trigger 0 source mux.
// Assumes event inputs and timer event pulses are synchronous to MCLK_I,
// and that software uses only full-word APB accesses.
//
// Summary of operation
// - Filter clock is kernel clock divided by two to the divide field.
// - Filter output changes only after N agreeing consecutive samples.
// - Code zero bypasses; codes one to three sample at kernel clock.
// - Codes four to nine sample filter clock over 2, 4, 8, N 6/8.
// - Codes ten to fifteen sample filter clock over 16 or 32.
// - Each upper event has its own four-bit filter code field.
// - Each upper event has own edge, polarity and source fields.
// - Event seven has a low latency select bit at bit 17.
// - Edge code zero is level with polarity; others pick edges.
// - Source field picks one of four inputs; software keeps it steady.
// - Normal mode adds a retiming stage; fast mode skips it.
// - Each trigger enable bit gates its own source event.
// - Bits 0..3 master compares, bit 4 master period.
// - Bits 5..9 take conditioned external events 0..4.
// - Bits 10..14 take sub-timer 0 compares, period, reset.
// - Bits 15..19 take sub-timer 1 compares, period, reset.
// - Bits 20..23 take sub-timer 2 compares and period.
// - Bits 24..27 take sub-timer 3 compares and period.
// - Bits 28..31 take sub-timer 4 compares and period.
// - Filter control and trigger sources reset to all zeros.
module eft_top
  import eft_pkg::*;
(
  input  wire logic        MCLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  input  wire logic [3:0]  PSTRB_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic [19:0] EXT_EVENT_SRC_I,
  input  wire logic [4:0]  COND_EVENT_LOW_I,
  input  wire logic [3:0]  MASTER_CMP_I,
  input  wire logic        MASTER_PERIOD_I,
  input  wire logic [14:0] SUB_CMP_I,
  input  wire logic [4:0]  SUB_PERIOD_I,
  input  wire logic [1:0]  SUB_RESET_I,
  output logic      [4:0]  COND_EVENT_UPPER_O,
  output logic             CONVERTER_TRIGGER_0_O
);

  // Register state
  logic [31:0] upper_cfg_reg;
  logic [31:0] filter_ctl_reg;
  logic [31:0] trig0_en_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [EFT_PRESCALE_W-1:0] prescale_reg;
  logic        trigger_reg;
  logic [4:0]  cond_reg;

  // APB address decode
  wire         hit_cfg   = (PADDR_I == EFT_UPPER_EVENT_CONFIG_OFS);
  wire         hit_flt   = (PADDR_I == EFT_EVENT_FILTER_CTRL_OFS);
  wire         hit_trg   = (PADDR_I == EFT_TRIG0_SOURCES_OFS);
  wire         hit_any   = hit_cfg | hit_flt | hit_trg;
  wire         setup     = PSEL_I & ~PENABLE_I;
  // Partial writes are refused so a register never holds a torn word
  wire         bad_strb  = PWRITE_I & (PSTRB_I != 4'hF);
  wire         req_err   = ~hit_any | bad_strb;
  wire         access_ok = PSEL_I & PENABLE_I & pready_reg & ~pslverr_reg;
  wire         wr_en     = access_ok & PWRITE_I;
  wire         wr_cfg    = wr_en & hit_cfg;
  wire         wr_flt    = wr_en & hit_flt;
  wire         wr_trg    = wr_en & hit_trg;

  // Read data selection, captured during the setup cycle
  wire [31:0]  rd_mux =
    hit_cfg ? upper_cfg_reg  :
    hit_flt ? filter_ctl_reg :
    hit_trg ? trig0_en_reg   : 32'h0000_0000;

  // Next register values; reserved bits dropped on write
  wire [31:0]  upper_cfg_next  = wr_cfg ?
    (PWDATA_I & EFT_UPPER_EVENT_CONFIG_MASK) : upper_cfg_reg;
  wire [31:0]  filter_ctl_next = wr_flt ?
    (PWDATA_I & EFT_EVENT_FILTER_CTRL_MASK) : filter_ctl_reg;
  wire [31:0]  trig0_en_next   = wr_trg ? PWDATA_I : trig0_en_reg;

  // Zero wait state answer: ready in the cycle after setup
  wire         pready_next  = setup;
  wire         pslverr_next = setup & req_err;
  wire [31:0]  prdata_next  = (setup & ~PWRITE_I & ~req_err) ?
    rd_mux : 32'h0000_0000;

  // Configuration registers
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      upper_cfg_reg  <= EFT_UPPER_EVENT_CONFIG_RST;
      filter_ctl_reg <= EFT_EVENT_FILTER_CTRL_RST;
      trig0_en_reg   <= EFT_TRIG0_SOURCES_RST;
    end else begin
      upper_cfg_reg  <= upper_cfg_next;
      filter_ctl_reg <= filter_ctl_next;
      trig0_en_reg   <= trig0_en_next;
    end
  end

  // APB answer registers
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg  <= prdata_next;
    end
  end

  // Free-running prescaler shared by all five filters
  wire [EFT_PRESCALE_W-1:0] prescale_next =
    prescale_reg + {{(EFT_PRESCALE_W-1){1'b0}}, 1'b1};

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      prescale_reg <= EFT_PRESCALE_RST;
    end else begin
      prescale_reg <= prescale_next;
    end
  end

  // Filter clock divide field, as a power of two
  wire [1:0]   fclk_div = filter_ctl_reg[EFT_FCLK_DIV_POS +: 2];

  // Per-event conditioning chain
  genvar k;
  generate
    for (k = 0; k < EFT_NUM_EVENTS; k++) begin : g_evt
      logic [2:0] cnt_reg;
      logic       dly_reg;
      logic       flt_reg;
      logic       prev_reg;
      logic [2:0] cnt_next;
      logic       flt_next;
      logic       cond_next;

      // Field extraction for this event
      wire [5:0]  cfg   = upper_cfg_reg[k*EFT_EVENT_STRIDE +: 6];
      wire [1:0]  src   = cfg[EFT_SRC_POS +: 2];
      wire        pol   = cfg[EFT_POL_POS];
      wire [1:0]  edge_sel = cfg[EFT_EDGE_POS +: 2];
      // Bit only writable for event seven; masked zero elsewhere
      wire        fast  = cfg[EFT_FAST_POS];
      wire [3:0]  fcode =
        filter_ctl_reg[k*EFT_EVENT_STRIDE + EFT_FCODE_POS +: 4];

      // Source choice among four inputs
      wire [3:0]  srcs  = EXT_EVENT_SRC_I[k*EFT_NUM_SOURCES +: 4];
      wire        raw   = srcs[src];

      // Normal mode pays a cycle of retiming, fast mode does not
      wire        in_sel = fast ? raw : dly_reg;

      // Sample tick: codes below four run at the kernel clock
      wire        use_fck = (fcode >= EFT_FCODE_FIRST_FCK);
      wire [3:0]  shift   = use_fck ?
        (4'({2'b00, fclk_div}) + EFT_FLT_RATE_LOG2[fcode]) : 4'h0;
      wire [8:0]  one_hot = 9'h001 << shift;
      wire [7:0]  tick_mask = one_hot[7:0] - 8'h01;
      wire        tick    = ((prescale_reg & tick_mask) == 8'h00);
      wire [2:0]  len_m1  = EFT_FLT_LEN_M1[fcode];

      // Counting filter: a mismatch must persist N samples
      always_comb begin
        cnt_next = cnt_reg;
        flt_next = flt_reg;
        if (fcode == EFT_FCODE_BYPASS) begin
          cnt_next = 3'h0;
          flt_next = in_sel;
        end else if (tick) begin
          if (in_sel == flt_reg) begin
            cnt_next = 3'h0;
          end else if (cnt_reg == len_m1) begin
            cnt_next = 3'h0;
            flt_next = in_sel;
          end else begin
            cnt_next = cnt_reg + 3'h1;
          end
        end
      end

      // Edge and polarity on the filtered level
      wire        rise = flt_reg & ~prev_reg;
      wire        fall = ~flt_reg & prev_reg;

      always_comb begin
        case (edge_sel)
          EFT_EDGE_LEVEL:   cond_next = flt_reg ^ pol;
          EFT_EDGE_RISING:  cond_next = rise;
          EFT_EDGE_FALLING: cond_next = fall;
          EFT_EDGE_BOTH:    cond_next = rise | fall;
          default:          cond_next = 1'b0;
        endcase
      end

      // Filter state; identical for every event
      always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
          dly_reg     <= 1'b0;
          cnt_reg     <= 3'h0;
          flt_reg     <= 1'b0;
          prev_reg    <= 1'b0;
          cond_reg[k] <= 1'b0;
        end else begin
          dly_reg     <= raw;
          cnt_reg     <= cnt_next;
          flt_reg     <= flt_next;
          prev_reg    <= flt_reg;
          cond_reg[k] <= cond_next;
        end
      end
    end
  endgenerate

  // Trigger source vector in enable bit order
  wire [EFT_NUM_TRIG_SRC-1:0] trig_events = {
    SUB_PERIOD_I[4], SUB_CMP_I[14:12],
    SUB_PERIOD_I[3], SUB_CMP_I[11:9],
    SUB_PERIOD_I[2], SUB_CMP_I[8:6],
    SUB_RESET_I[1], SUB_PERIOD_I[1], SUB_CMP_I[5:3],
    SUB_RESET_I[0], SUB_PERIOD_I[0], SUB_CMP_I[2:0],
    COND_EVENT_LOW_I,
    MASTER_PERIOD_I, MASTER_CMP_I
  };

  // Gate by enables and merge coincident events into one pulse
  wire [EFT_NUM_TRIG_SRC-1:0] trig_gated = trig_events & trig0_en_reg;
  wire         trigger_next = |trig_gated;

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      trigger_reg <= 1'b0;
    end else begin
      trigger_reg <= trigger_next;
    end
  end

  // Outputs straight from flip-flops
  assign PRDATA_O              = prdata_reg;
  assign PREADY_O              = pready_reg;
  assign PSLVERR_O             = pslverr_reg;
  assign COND_EVENT_UPPER_O    = cond_reg;
  assign CONVERTER_TRIGGER_0_O = trigger_reg;

endmodule

// ---- test/eft_adc_model.sv ----
// Converter trigger input model: counts trigger cycles it receives.
// Assumes one kernel clock shared with the block under test.
module eft_adc_model (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic trig_i,
  output int        count_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Each high cycle starts one conversion, merged sources included
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) count_o <= 0;
    else if (trig_i === 1'b1) count_o <= count_o + 1;
  end
endmodule

// ---- test/eft_top_assertions.sv ----
// Port-level checks of APB answers and the trigger merge.
// Assumes full-word APB masters and the register map of eft_pkg.
module eft_top_chk
  import eft_pkg::*;
(
  input wire logic        MCLK_I,
  input wire logic        RESET_N_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0]  PSTRB_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic [4:0]  COND_EVENT_LOW_I,
  input wire logic [3:0]  MASTER_CMP_I,
  input wire logic        MASTER_PERIOD_I,
  input wire logic [14:0] SUB_CMP_I,
  input wire logic [4:0]  SUB_PERIOD_I,
  input wire logic [1:0]  SUB_RESET_I,
  input wire logic        CONVERTER_TRIGGER_0_O
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] trg_reg, fc_reg, ev;
  // Shadow copies follow only accepted full-word writes
  wire setup = PSEL_I && !PENABLE_I;
  wire wr_ok = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && !PSLVERR_O;
  wire mapped = PADDR_I == EFT_UPPER_EVENT_CONFIG_OFS ||
    PADDR_I == EFT_EVENT_FILTER_CTRL_OFS || PADDR_I == EFT_TRIG0_SOURCES_OFS;
  wire bad = !mapped || (PWRITE_I && PSTRB_I != 4'hF);
  assign ev = {SUB_PERIOD_I[4], SUB_CMP_I[14:12], SUB_PERIOD_I[3],
    SUB_CMP_I[11:9], SUB_PERIOD_I[2], SUB_CMP_I[8:6], SUB_RESET_I[1],
    SUB_PERIOD_I[1], SUB_CMP_I[5:3], SUB_RESET_I[0], SUB_PERIOD_I[0],
    SUB_CMP_I[2:0], COND_EVENT_LOW_I, MASTER_PERIOD_I, MASTER_CMP_I};
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      trg_reg <= 32'h0000_0000;
      fc_reg  <= 32'h0000_0000;
    end else if (wr_ok && PADDR_I == EFT_TRIG0_SOURCES_OFS) begin
      trg_reg <= PWDATA_I;
    end else if (wr_ok && PADDR_I == EFT_EVENT_FILTER_CTRL_OFS) begin
      fc_reg <= PWDATA_I & EFT_EVENT_FILTER_CTRL_MASK;
    end
  end
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RESET_N_I);
  property p_ready; setup |=> PREADY_O; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_ready_only; PREADY_O |-> $past(setup); endproperty
  a_ready_only: assert property (p_ready_only)
    else $error("stray ready");
  property p_err; PREADY_O |-> PSLVERR_O == $past(bad); endproperty
  a_err: assert property (p_err) else $error("bad error");
  property p_err_only; PSLVERR_O |-> PREADY_O; endproperty
  a_err_only: assert property (p_err_only) else $error("lone err");
  property p_rd_idle; !PREADY_O || PSLVERR_O |-> PRDATA_O == 0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata");
  property p_rd_trg;
    PREADY_O && !PWRITE_I && PADDR_I == EFT_TRIG0_SOURCES_OFS
      |-> PRDATA_O == trg_reg;
  endproperty
  a_rd_trg: assert property (p_rd_trg) else $error("trg read");
  property p_rd_fc;
    PREADY_O && !PWRITE_I && PADDR_I == EFT_EVENT_FILTER_CTRL_OFS
      |-> PRDATA_O == fc_reg;
  endproperty
  a_rd_fc: assert property (p_rd_fc) else $error("fc read");
  property p_trig;
    CONVERTER_TRIGGER_0_O == |($past(ev) & $past(trg_reg));
  endproperty
  a_trig: assert property (p_trig) else $error("trigger");
  c_wr: cover property (wr_ok);
  c_err: cover property (PSLVERR_O);
  c_trig: cover property (CONVERTER_TRIGGER_0_O);
endmodule
bind eft_top eft_top_chk u_chk (.*);

// ---- test/eft_top_test.sv ----
// Self-checking bench: registers, trigger mux, filters, edges, fast mode.
// Assumes the converter model counts trigger cycles at the far side.
module eft_top_test
  import eft_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [11:0] UEC = EFT_UPPER_EVENT_CONFIG_OFS;
  localparam logic [11:0] FC = EFT_EVENT_FILTER_CTRL_OFS;
  localparam logic [11:0] TS = EFT_TRIG0_SOURCES_OFS;
  logic clk, rst_n, psel, pen, pwr, pready, er, trig, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, ev;
  logic [3:0] pstrb;
  logic [19:0] src;
  logic [4:0] cond;
  int failures, compares, cnt;
  eft_top dut (.MCLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(er),
    .EXT_EVENT_SRC_I(src), .COND_EVENT_LOW_I(ev[9:5]),
    .MASTER_CMP_I(ev[3:0]), .MASTER_PERIOD_I(ev[4]),
    .SUB_CMP_I({ev[30:28], ev[26:24], ev[22:20], ev[17:15], ev[12:10]}),
    .SUB_PERIOD_I({ev[31], ev[27], ev[23], ev[18], ev[13]}),
    .SUB_RESET_I({ev[19], ev[14]}), .COND_EVENT_UPPER_O(cond),
    .CONVERTER_TRIGGER_0_O(trig));
  eft_adc_model u_adc (.clk_i(clk), .rst_n_i(rst_n), .trig_i(trig),
    .count_o(cnt));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; answer taken at the edge where ready is seen
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk);
    {psel, pen, pwr, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
    @(posedge clk);
    pen <= 1'b1;
    // Answer and read data are taken at the rising edge that sees ready
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (psel === 1'b1 && pen === 1'b1 && pready === 1'b1) break;
    end
    if (n == 16) begin
      failures++;
      summarize();
    end
    rd = prdata;
    rerr = er;
    {psel, pen} <= 2'b00;
  endtask
  task automatic wr(input logic [11:0] a, input int d);
    apb(1'b1, a, 32'(d), 4'hF);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, 4'hF);
    chk(rd, e);
  endtask
  // Cycles from input change until the conditioned output shows l
  task automatic lat(input int b, input logic l, output int n);
    for (n = 0; n < 4000; n++) begin
      @(negedge clk);
      if (cond[b] === l) break;
    end
    if (n == 4000) begin
      failures++;
      summarize();
    end
  endtask
  task automatic t_regs;
    rdchk(UEC, 0);
    rdchk(FC, 0);
    rdchk(TS, 0);
    wr(FC, 32'hCF3C_F3CF);
    rdchk(FC, 32'hCF3C_F3CF);
    wr(UEC, -1);
    rdchk(UEC, 32'h1F7F_F7DF);
    apb(1'b0, 12'h040, 32'h0000_0000, 4'hF);
    chk({31'h0, rerr}, 1);
    apb(1'b1, TS, 32'hFFFF_FFFF, 4'h3);
    chk({31'h0, rerr}, 1);
    rdchk(TS, 0);
    wr(UEC, 0);
    wr(FC, 0);
  endtask
  task automatic pulse(input logic [31:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= '0;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_trig;
    int i, c;
    for (i = 0; i < 32; i++) begin
      wr(TS, 1 << i);
      c = cnt;
      pulse(~(32'h1 << i));
      chk(32'(cnt - c), 0);
      pulse(32'h1 << i);
      chk(32'(cnt - c), 1);
    end
    wr(TS, -1);
    c = cnt;
    pulse('1);
    chk(32'(cnt - c), 1);
    wr(TS, 0);
  endtask
  task automatic t_filt;
    int c, e, s, d, nn, p, n, l;
    for (c = 1; c < 16; c++) begin
      e = c % 5;
      s = c % 4;
      d = c % 4;
      nn = c < 4 ? 1 << c : c < 10 ? (c % 2 ? 8 : 6) :
           (c - 10) % 3 == 0 ? 5 : (c - 10) % 3 == 1 ? 6 : 8;
      p = c < 4 ? 1 : 1 << (d + (c < 10 ? (c - 2) / 2 : c < 13 ? 4 : 5));
      wr(UEC, s << (6 * e));
      wr(FC, (d << 30) | (c << (6 * e)));
      for (l = 1; l >= 0; l--) begin
        @(posedge clk);
        src <= 20'(l) << (4 * e + s);
        lat(e, l[0], n);
        chk(32'(n >= (nn - 1) * p + 2 && n <= nn * p + 3), 1);
      end
    end
    wr(FC, 0);
  endtask
  task automatic t_edge;
    int g, k, h;
    for (g = 1; g < 4; g++) begin
      wr(UEC, (g << 9) | (1 << 6));
      h = 0;
      @(posedge clk);
      src <= 20'h0_0020;
      for (k = 0; k < 16; k++) begin
        @(negedge clk);
        h += (cond[1] === 1'b1);
        @(posedge clk);
        if (k == 6) src <= '0;
      end
      chk(h, g == 3 ? 2 : 1);
    end
    wr(UEC, (1 << 6) | (1 << 8));
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk({31'h0, cond[1]}, 1);
    wr(UEC, 0);
  endtask
  task automatic t_fast;
    int f, n;
    for (f = 0; f < 2; f++) begin
      wr(UEC, f << 17);
      @(posedge clk);
      src <= 20'h0_0100;
      lat(2, 1'b1, n);
      chk(n, 3 - f);
      @(posedge clk);
      src <= '0;
      lat(2, 1'b0, n);
    end
    wr(UEC, 0);
  endtask
  task automatic summarize;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    {psel, pen, pwr, paddr, pwdata, ev, src} = '0;
    pstrb = 4'hF;
    rst_n = 1'b0;
    failures = 0;
    compares = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_trig;
    t_filt;
    t_edge;
    t_fast;
    summarize;
  end
endmodule
